// file: core/rtck_core.sv
// Purpose: timekeeping registers, BCD calendar and read snapshot
// Assumes: register port strobes are synchronous one-cycle pulses
// Notes: writes go to the live counters, timekeeping reads come from the snapshot, control is read live
`timescale 1ns/10ps
`include "rtck_map.svh"
module rtck_core #(
    parameter int unsigned OSF_CYCLES = `RTCK_OSF_CYCLES
) (
    // clock and reset
    input wire logic clk,
    input wire logic resetn,
    // oscillator pin level
    input wire logic x1_in,
    // primary power lost event
    input wire logic power_lost,
    // register write port
    input wire logic wr_en,
    input wire logic [7:0] wr_addr,
    input wire logic [7:0] wr_data,
    // register read port
    input wire logic rd_start,
    input wire logic rd_next,
    input wire logic [7:0] rd_addr,
    output logic [7:0] rd_data,
    // status
    output logic oscillator_alive_flag
);
    rtck_osc_if osc_link();

    rtck_osc_mon #(
        .OSF_CYCLES(OSF_CYCLES)
    ) u_mon (
        .clk(clk),
        .resetn(resetn),
        .x1_in(x1_in),
        .osc(osc_link.mon)
    );

    function automatic logic [7:0] bcd_inc(input logic [7:0] v);
        logic [7:0] r;
        r = (v[3:0] == 4'h9) ? {v[7:4] + 4'h1, 4'h0} : {v[7:4], v[3:0] + 4'h1};
        return r;
    endfunction

    function automatic logic [5:0] max_date(input logic [4:0] m, input logic leap);
        logic [5:0] r;
        case (m)
            5'h02: r = leap ? `RTCK_DATE_29 : `RTCK_DATE_28;
            5'h04, 5'h06, 5'h09, 5'h11: r = `RTCK_DATE_30;
            default: r = `RTCK_DATE_31;
        endcase
        return r;
    endfunction

    // live counters, packed BCD
    logic [7:0] hsec_q;
    logic [6:0] sec_q;
    logic go_q;
    logic [6:0] min_q;
    logic [6:0] hour_q;
    logic trim_q;
    logic [2:0] weekday_value_q;
    logic pwr_q;
    logic vbat_q;
    logic [5:0] date_q;
    logic [4:0] mth_q;
    logic [7:0] year_q;
    logic [6:0] ctrl_q;
    // read side
    logic [7:0] rd_addr_q;
    logic [7:0] rd_data_q;
    rtck_pkg::rtck_byte_t snap_q [0:`RTCK_TK_REGS-1];
    rtck_pkg::rtck_byte_t live [0:`RTCK_TK_REGS-1];

    // write decode
    wire wr_hsec = wr_en & (wr_addr == `RTCK_ADDR_HSEC);
    wire wr_sec = wr_en & (wr_addr == `RTCK_ADDR_SEC);
    wire wr_min = wr_en & (wr_addr == `RTCK_ADDR_MIN);
    wire wr_hour = wr_en & (wr_addr == `RTCK_ADDR_HOUR);
    wire wr_weekday_value = wr_en & (wr_addr == `RTCK_ADDR_WEEKDAY_VALUE);
    wire wr_date = wr_en & (wr_addr == `RTCK_ADDR_DATE);
    wire wr_mth = wr_en & (wr_addr == `RTCK_ADDR_MTH);
    wire wr_year = wr_en & (wr_addr == `RTCK_ADDR_YEAR);
    wire wr_ctrl = wr_en & (wr_addr == `RTCK_ADDR_CTRL);

    // crystal runs on the start bit, an external clock on its select bit
    wire external_clock_select = ctrl_q[`RTCK_CTRL_EXT_BIT];
    assign osc_link.osc_enable = go_q | external_clock_select;

    // the chain never looks at the supply source, so backup keeps counting
    wire step = osc_link.hund_step;

    // hundredths and seconds, minutes
    wire hsec_wrap = (hsec_q == `RTCK_HSEC_LAST);
    wire sec_wrap = (sec_q == `RTCK_MIN_SEC_LAST);
    wire min_wrap = (min_q == `RTCK_MIN_SEC_LAST);
    wire carry_sec = step & hsec_wrap;
    wire carry_min = carry_sec & sec_wrap;
    wire carry_hour = carry_min & min_wrap;
    wire [7:0] hsec_inc = bcd_inc(hsec_q);
    wire [7:0] sec_inc = bcd_inc({1'b0, sec_q});
    wire [7:0] min_inc = bcd_inc({1'b0, min_q});

    // hours in both formats
    wire mode12 = hour_q[`RTCK_HOUR_MODE_BIT];
    wire afternoon_flag = hour_q[`RTCK_HOUR_PM_BIT];
    wire [4:0] h12 = hour_q[4:0];
    wire [5:0] h24 = hour_q[5:0];
    wire h12_eleven = (h12 == `RTCK_H12_ELEVEN);
    wire h12_noon = (h12 == `RTCK_H12_NOON);
    wire h24_last = (h24 == `RTCK_H24_LAST);
    wire [7:0] h12_inc = bcd_inc({3'b000, h12});
    wire [7:0] h24_inc = bcd_inc({2'b00, h24});
    wire day_wrap = mode12 ? (h12_eleven & afternoon_flag) : h24_last;
    logic [6:0] hour_next;
    always_comb begin
        if (mode12) begin
            if (h12_eleven) begin
                hour_next = {1'b1, ~afternoon_flag, `RTCK_H12_NOON};
            end else if (h12_noon) begin
                hour_next = {1'b1, afternoon_flag, `RTCK_H12_FIRST};
            end else begin
                hour_next = {1'b1, afternoon_flag, h12_inc[4:0]};
            end
        end else begin
            hour_next = h24_last ? 7'h00 : {1'b0, h24_inc[5:0]};
        end
    end

    // leap year from the two BCD digits: multiples of four
    wire year_leap = year_q[4] ? (year_q[3:0] == 4'h2 || year_q[3:0] == 4'h6)
                               : (year_q[3:0] == 4'h0 || year_q[3:0] == 4'h4 ||
                                  year_q[3:0] == 4'h8);

    // date, weekday, month, year
    wire carry_day = carry_hour & day_wrap;
    wire date_wrap = (date_q == max_date(mth_q, year_leap));
    wire carry_mth = carry_day & date_wrap;
    wire mth_wrap = (mth_q == `RTCK_MTH_LAST);
    wire carry_year = carry_mth & mth_wrap;
    wire year_wrap = (year_q == `RTCK_YEAR_LAST);
    wire weekday_value_wrap = (weekday_value_q == `RTCK_WEEKDAY_VALUE_LAST);
    wire [7:0] date_inc = bcd_inc({2'b00, date_q});
    wire [7:0] mth_inc = bcd_inc({3'b000, mth_q});
    wire [7:0] year_inc = bcd_inc(year_q);

    // next values, a host write wins over the count for its own register
    wire [7:0] hsec_d = wr_hsec ? wr_data :
                        step ? (hsec_wrap ? 8'h00 : hsec_inc) : hsec_q;
    wire [6:0] sec_d = wr_sec ? wr_data[6:0] :
                       carry_sec ? (sec_wrap ? 7'h00 : sec_inc[6:0]) : sec_q;
    wire go_d = wr_sec ? wr_data[`RTCK_SEC_GO_BIT] : go_q;
    wire [6:0] min_d = wr_min ? wr_data[6:0] :
                       carry_min ? (min_wrap ? 7'h00 : min_inc[6:0]) : min_q;
    wire [6:0] hour_d = wr_hour ? wr_data[6:0] : carry_hour ? hour_next : hour_q;
    wire trim_d = wr_hour ? wr_data[`RTCK_HOUR_TRIM_BIT] : trim_q;
    wire [2:0] weekday_value_d = wr_weekday_value ? wr_data[2:0] :
                         carry_day ? (weekday_value_wrap ? 3'h1 : weekday_value_q + 3'h1) : weekday_value_q;
    // software may only clear the loss flag; a new event wins over the clear
    wire pwr_clr = wr_weekday_value & ~wr_data[`RTCK_WK_PWR_BIT];
    wire pwr_d = power_lost | (pwr_q & ~pwr_clr);
    wire vbat_d = wr_weekday_value ? wr_data[`RTCK_WK_VBAT_BIT] : vbat_q;
    wire [5:0] date_d = wr_date ? wr_data[5:0] :
                        carry_day ? (date_wrap ? 6'h01 : date_inc[5:0]) : date_q;
    wire [4:0] mth_d = wr_mth ? wr_data[4:0] :
                       carry_mth ? (mth_wrap ? 5'h01 : mth_inc[4:0]) : mth_q;
    wire [7:0] year_d = wr_year ? wr_data :
                        carry_year ? (year_wrap ? 8'h00 : year_inc) : year_q;
    wire [6:0] ctrl_d = wr_ctrl ? wr_data[6:0] : ctrl_q;

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            hsec_q <= `RTCK_RST_HSEC;
            sec_q <= `RTCK_RST_SEC;
            go_q <= 1'b0;
            min_q <= `RTCK_RST_MIN;
            hour_q <= `RTCK_RST_HOUR;
            trim_q <= 1'b0;
        end else begin
            hsec_q <= hsec_d;
            sec_q <= sec_d;
            go_q <= go_d;
            min_q <= min_d;
            hour_q <= hour_d;
            trim_q <= trim_d;
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            weekday_value_q <= `RTCK_RST_WEEKDAY_VALUE;
            pwr_q <= 1'b0;
            vbat_q <= 1'b0;
            date_q <= `RTCK_RST_DATE;
            mth_q <= `RTCK_RST_MTH;
            year_q <= `RTCK_RST_YEAR;
            ctrl_q <= `RTCK_RST_CTRL;
        end else begin
            weekday_value_q <= weekday_value_d;
            pwr_q <= pwr_d;
            vbat_q <= vbat_d;
            date_q <= date_d;
            mth_q <= mth_d;
            year_q <= year_d;
            ctrl_q <= ctrl_d;
        end
    end

    // register images as software sees them, unused bits read zero
    assign live[0] = hsec_q;
    assign live[1] = {go_q, sec_q};
    assign live[2] = {1'b0, min_q};
    assign live[3] = {trim_q, hour_q};
    assign live[4] = {2'b00, osc_link.alive, pwr_q, vbat_q, weekday_value_q};
    assign live[5] = {2'b00, date_q};
    assign live[6] = {2'b00, year_leap, mth_q};
    assign live[7] = year_q;

    // read address walk and snapshot refresh
    wire rd_at_top = (rd_addr_q == `RTCK_ADDR_TOP);
    wire [7:0] rd_addr_inc = rd_at_top ? 8'h00 : rd_addr_q + 8'h01;
    wire rd_start_tk = rd_start & (rd_addr <= `RTCK_ADDR_TOP);
    wire refresh = rd_start_tk | (rd_next & rd_at_top);
    wire [7:0] rd_addr_d = rd_start ? rd_addr : (rd_next ? rd_addr_inc : rd_addr_q);
    wire rd_in_tk = (rd_addr_d < 8'(`RTCK_TK_REGS));
    wire [2:0] rd_idx = rd_addr_d[2:0];
    // on a refresh the answer is taken from the same values the snapshot grabs
    wire [7:0] rd_tk_byte = refresh ? live[rd_idx] : snap_q[rd_idx];
    wire [7:0] rd_byte = rd_in_tk ? rd_tk_byte :
                         (rd_addr_d == `RTCK_ADDR_CTRL) ? {1'b0, ctrl_q} : 8'h00;
    wire rd_take = rd_start | rd_next;
    wire [7:0] rd_data_d = rd_take ? rd_byte : rd_data_q;

    for (genvar i = 0; i < `RTCK_TK_REGS; i++) begin : g_snap
        always_ff @(posedge clk or negedge resetn) begin
            if (!resetn) begin
                snap_q[i] <= 8'h00;
            end else if (refresh) begin
                snap_q[i] <= live[i];
            end
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            rd_addr_q <= 8'h00;
            rd_data_q <= 8'h00;
        end else begin
            rd_addr_q <= rd_addr_d;
            rd_data_q <= rd_data_d;
        end
    end

    assign rd_data = rd_data_q;
    assign oscillator_alive_flag = osc_link.alive;
endmodule

// file: core/rtck_osc_mon.sv
// Purpose: oscillator-running detection and hundredths tick generation
// Assumes: x1_in is synchronous to clk and far slower than clk
// Notes: fail timeout is a parameter so simulation can shorten it
`timescale 1ns/10ps
`include "rtck_map.svh"
module rtck_osc_mon #(
    parameter int unsigned OSF_CYCLES = `RTCK_OSF_CYCLES
) (
    // clock and reset
    input wire logic clk,
    input wire logic resetn,
    // sampled oscillator level
    input wire logic x1_in,
    // towards the core
    rtck_osc_if.mon osc
);
    localparam int CW = $clog2(OSF_CYCLES + 1);
    logic x1_q;
    logic [CW-1:0] quiet_q;
    logic [4:0] start_q;
    logic [2:0] div_q;
    logic [5:0] pre_q;
    logic [4:0] step_q;
    logic alive_q;
    logic hstep_q;
    rtck_pkg::rtck_osc_state_t state_q;
    rtck_pkg::rtck_osc_state_t state_d;

    // a disabled source shows no edges, so the timeout also covers a stop
    wire edge_seen = osc.osc_enable & x1_in & ~x1_q;
    wire timed_out = (quiet_q == CW'(OSF_CYCLES));
    wire last_start = (start_q == 5'(`RTCK_START_EDGES - 1));
    wire tick4k = edge_seen & (div_q == 3'(`RTCK_EDGES_PER_TICK - 1));
    wire short_step = (step_q == 5'(`RTCK_LONG_STEPS));
    wire [5:0] pre_last = short_step ? 6'(`RTCK_TICKS_SHORT - 1) : 6'(`RTCK_TICKS_LONG - 1);
    wire step_done = tick4k & (pre_q == pre_last);

    always_comb begin
        state_d = state_q;
        case (state_q)
            rtck_pkg::RTCK_OSC_STOP: begin
                if (edge_seen) state_d = rtck_pkg::RTCK_OSC_START;
            end
            rtck_pkg::RTCK_OSC_START: begin
                if (timed_out) state_d = rtck_pkg::RTCK_OSC_STOP;
                else if (edge_seen && last_start) state_d = rtck_pkg::RTCK_OSC_RUN;
            end
            rtck_pkg::RTCK_OSC_RUN: begin
                if (timed_out) state_d = rtck_pkg::RTCK_OSC_STOP;
            end
            default: state_d = rtck_pkg::RTCK_OSC_STOP;
        endcase
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            x1_q <= 1'b0;
            state_q <= rtck_pkg::RTCK_OSC_STOP;
            alive_q <= 1'b0;
        end else begin
            x1_q <= x1_in;
            state_q <= state_d;
            alive_q <= (state_d == rtck_pkg::RTCK_OSC_RUN);
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            quiet_q <= '0;
            start_q <= 5'h00;
        end else begin
            quiet_q <= edge_seen ? '0 : (timed_out ? quiet_q : quiet_q + CW'(1));
            if ((timed_out && !edge_seen) || state_q == rtck_pkg::RTCK_OSC_RUN) start_q <= 5'h00;
            else if (edge_seen) start_q <= start_q + 5'h01;
        end
    end

    // 41/40 pacing keeps each group of 25 steps at exactly 250 ms
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            div_q <= 3'h0;
            pre_q <= 6'h00;
            step_q <= 5'h00;
            hstep_q <= 1'b0;
        end else begin
            if (edge_seen) div_q <= div_q + 3'h1;
            if (step_done) pre_q <= 6'h00;
            else if (tick4k) pre_q <= pre_q + 6'h01;
            if (step_done) step_q <= short_step ? 5'h00 : step_q + 5'h01;
            hstep_q <= step_done;
        end
    end

    assign osc.alive = alive_q;
    assign osc.hund_step = hstep_q;
endmodule

// file: inc/rtck_map.svh
// Purpose: register map, field positions, reset values and timing counts
// Assumes: 25 MHz core clock, 32.768 kHz source sampled on the core clock
// Notes: the defines below are shared by the core and the oscillator monitor
`ifndef RTCK_MAP_SVH
`define RTCK_MAP_SVH

`define RTCK_ADDR_HSEC 8'h00
`define RTCK_ADDR_SEC 8'h01
`define RTCK_ADDR_MIN 8'h02
`define RTCK_ADDR_HOUR 8'h03
`define RTCK_ADDR_WEEKDAY_VALUE 8'h04
`define RTCK_ADDR_DATE 8'h05
`define RTCK_ADDR_MTH 8'h06
`define RTCK_ADDR_YEAR 8'h07
`define RTCK_ADDR_CTRL 8'h08
`define RTCK_ADDR_TOP 8'h1F
`define RTCK_TK_REGS 8

`define RTCK_SEC_GO_BIT 7
`define RTCK_HOUR_TRIM_BIT 7
`define RTCK_HOUR_MODE_BIT 6
`define RTCK_HOUR_PM_BIT 5
`define RTCK_WK_PWR_BIT 4
`define RTCK_WK_VBAT_BIT 3
`define RTCK_CTRL_EXT_BIT 3

`define RTCK_RST_HSEC 8'h00
`define RTCK_RST_SEC 7'h00
`define RTCK_RST_MIN 7'h00
`define RTCK_RST_HOUR 7'h00
`define RTCK_RST_WEEKDAY_VALUE 3'h1
`define RTCK_RST_DATE 6'h01
`define RTCK_RST_MTH 5'h01
`define RTCK_RST_YEAR 8'h01
`define RTCK_RST_CTRL 7'h00

`define RTCK_HSEC_LAST 8'h99
`define RTCK_MIN_SEC_LAST 7'h59
`define RTCK_H24_LAST 6'h23
`define RTCK_H12_ELEVEN 5'h11
`define RTCK_H12_NOON 5'h12
`define RTCK_H12_FIRST 5'h01
`define RTCK_WEEKDAY_VALUE_LAST 3'h7
`define RTCK_MTH_LAST 5'h12
`define RTCK_YEAR_LAST 8'h99
`define RTCK_DATE_31 6'h31
`define RTCK_DATE_30 6'h30
`define RTCK_DATE_29 6'h29
`define RTCK_DATE_28 6'h28

`define RTCK_CLK_MHZ 25
`define RTCK_TOSF_US 200
`define RTCK_OSF_CYCLES (`RTCK_TOSF_US * `RTCK_CLK_MHZ)
`define RTCK_START_EDGES 32
`define RTCK_EDGES_PER_TICK 8
`define RTCK_TICKS_LONG 41
`define RTCK_TICKS_SHORT 40
`define RTCK_LONG_STEPS 24

`endif

// file: inc/rtck_osc_if.sv
// Purpose: link between the core and the oscillator monitor
// Assumes: single clock domain
// Notes: hund_step is a one-cycle pulse
`timescale 1ns/10ps
interface rtck_osc_if;
    logic osc_enable;
    logic alive;
    logic hund_step;
    modport core (output osc_enable, input alive, input hund_step);
    modport mon (input osc_enable, output alive, output hund_step);
endinterface

// file: inc/rtck_pkg.sv
// Purpose: shared types of the timekeeping core
// Assumes: nothing
// Notes: constants live in rtck_map.svh
package rtck_pkg;
    typedef enum logic [2:0] {
        RTCK_OSC_STOP = 3'b001,
        RTCK_OSC_START = 3'b010,
        RTCK_OSC_RUN = 3'b100
    } rtck_osc_state_t;
    typedef logic [7:0] rtck_byte_t;
endpackage

// file: sim/rtck_core_chk.sv
// Purpose: port checks for the timekeeping core
// Assumes: the host writes only valid bcd values
// Notes: enable bits mirrored from writes to count edges
`timescale 1ns/10ps
module rtck_core_chk #(
    parameter int unsigned OSF_CYCLES = 64
) (
    // clock and reset
    input wire logic clk,
    input wire logic resetn,
    // oscillator and events
    input wire logic x1_in,
    input wire logic power_lost,
    // write port
    input wire logic wr_en,
    input wire logic [7:0] wr_addr,
    input wire logic [7:0] wr_data,
    // read port
    input wire logic rd_start,
    input wire logic rd_next,
    input wire logic [7:0] rd_addr,
    input wire logic [7:0] rd_data,
    // status
    input wire logic oscillator_alive_flag
);
    logic go_q;
    logic ext_q;
    logic x1_q;
    logic [7:0] ptr_q;
    logic [7:0] edges_q;
    int unsigned quiet_q;
    wire logic en_on = go_q || ext_q;
    wire logic en_rise = x1_in && !x1_q && en_on;
    wire logic ptr_wrap = rd_next && ptr_q == 8'h1F;
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            {go_q, ext_q, x1_q} <= 3'b000;
            ptr_q <= 8'h00;
            edges_q <= 8'h00;
            quiet_q <= 0;
        end else begin
            x1_q <= x1_in;
            go_q <= (wr_en && wr_addr == 8'h01) ? wr_data[7] : go_q;
            ext_q <= (wr_en && wr_addr == 8'h08) ? wr_data[3] : ext_q;
            ptr_q <= rd_start ? rd_addr : (ptr_wrap ? 8'h00 : ptr_q + {7'h00, rd_next});
            edges_q <= (oscillator_alive_flag || !en_on) ? 8'h00
                : edges_q + {7'h00, en_rise && edges_q != 8'hFF};
            quiet_q <= en_rise ? 0 : (quiet_q < OSF_CYCLES + 16 ? quiet_q + 1 : quiet_q);
        end
    end
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!resetn);
    sequence read_taken;
        rd_start || rd_next;
    endsequence
    reset_clear_a:
        assert property (disable iff (1'b0) !resetn |-> rd_data == 8'h00 && !oscillator_alive_flag)
        else $error("outputs not clear in reset");
    alive_early_a:
        assert property ($rose(oscillator_alive_flag) |-> edges_q >= 8'h20)
        else $error("alive flag before 32 edges");
    alive_due_a:
        assert property (edges_q >= 8'h20 |-> oscillator_alive_flag)
        else $error("alive flag missing after 32 edges");
    alive_hold_a:
        assert property ($fell(oscillator_alive_flag) |-> quiet_q >= OSF_CYCLES - 8)
        else $error("alive flag dropped too early");
    alive_drop_a:
        assert property (quiet_q >= OSF_CYCLES + 8 |-> !oscillator_alive_flag)
        else $error("alive flag kept after timeout");
    read_hold_a:
        assert property (!rd_start && !rd_next |=> $stable(rd_data))
        else $error("read data moved without request");
    unmapped_zero_a:
        assert property (read_taken |=> ptr_q < 8'h09 || rd_data == 8'h00)
        else $error("unmapped address read nonzero");
    hsec_bcd_a:
        assert property (read_taken |=> ptr_q != 8'h00
            || (rd_data[7:4] <= 4'h9 && rd_data[3:0] <= 4'h9))
        else $error("hundredths not bcd");
    sec_min_bcd_a:
        assert property (read_taken |=> !(ptr_q inside {8'h01, 8'h02})
            || (rd_data[6:4] <= 3'h5 && rd_data[3:0] <= 4'h9 && (ptr_q == 8'h01 || !rd_data[7])))
        else $error("seconds or minutes field out of range");
    hour_field_a:
        assert property (read_taken |=> ptr_q != 8'h03 || (rd_data[6]
            ? rd_data[4:0] inside {[5'h01:5'h09], [5'h10:5'h12]}
            : (rd_data[5:0] <= 6'h23 && rd_data[3:0] <= 4'h9)))
        else $error("hour field out of range");
    weekday_range_a:
        assert property (read_taken |=> ptr_q != 8'h04
            || (rd_data[7:6] == 2'b00 && rd_data[2:0] != 3'h0))
        else $error("weekday out of range");
endmodule
bind rtck_core rtck_core_chk #(.OSF_CYCLES(OSF_CYCLES)) rtck_core_chk_inst (.clk(clk),
    .resetn(resetn), .x1_in(x1_in), .power_lost(power_lost), .wr_en(wr_en), .wr_addr(wr_addr),
    .wr_data(wr_data), .rd_start(rd_start), .rd_next(rd_next), .rd_addr(rd_addr),
    .rd_data(rd_data), .oscillator_alive_flag(oscillator_alive_flag));

// file: sim/rtck_host_model.sv
// Purpose: host and oscillator source facing the timekeeping core
// Assumes: strobes change just after the rising clock edge
// Notes: fast x1 keeps a step to thousands of cycles
`timescale 1ns/10ps
module rtck_host_model #(
    parameter int X1_HALF = 4
) (
    // clock
    input wire logic clk,
    // oscillator and events
    output logic x1_in,
    output logic power_lost,
    // register ports
    output logic wr_en,
    output logic [7:0] wr_addr,
    output logic [7:0] wr_data,
    output logic rd_start,
    output logic rd_next,
    output logic [7:0] rd_addr,
    input wire logic [7:0] rd_data,
    input wire logic oscillator_alive_flag
);
    logic [7:0] rd_buf [0:63];
    int x1_cnt = 0;
    initial begin
        {x1_in, power_lost, wr_en, rd_start, rd_next} = 5'b00000;
        {wr_addr, wr_data, rd_addr} = 24'h000000;
    end
    always @(posedge clk) begin
        #1;
        x1_cnt = (x1_cnt + 1) % X1_HALF;
        if (x1_cnt == 0) x1_in = !x1_in;
    end
    task automatic write_reg(input logic [7:0] a, d);
        @(posedge clk);
        #1;
        {wr_en, wr_addr, wr_data} = {1'b1, a, d};
        @(posedge clk);
        #1;
        wr_en = 1'b0;
    endtask
    // one burst, so the bytes share a snapshot
    task automatic read_burst(input logic [7:0] a, input int n);
        @(posedge clk);
        #1;
        {rd_start, rd_addr} = {1'b1, a};
        for (int i = 0; i < n; i++) begin
            @(posedge clk);
            #1;
            rd_start = 1'b0;
            rd_next = (i < n - 1);
            rd_buf[i] = rd_data;
        end
    endtask
    task automatic wait_alive(input logic lvl, output int n);
        n = 0;
        while (oscillator_alive_flag !== lvl && n < 2000) begin
            @(posedge clk);
            #1;
            n++;
        end
    endtask
    // stop, await the flag drop, load bcd, restart
    task automatic load_time(input logic [7:0] hr, wk, dt, mo, yr);
        int n;
        write_reg(8'h01, 8'h00);
        wait_alive(1'b0, n);
        write_reg(8'h00, 8'h98);
        write_reg(8'h02, 8'h59);
        write_reg(8'h03, hr);
        write_reg(8'h04, wk);
        write_reg(8'h05, dt);
        write_reg(8'h06, mo);
        write_reg(8'h07, yr);
        write_reg(8'h01, 8'hD9);
    endtask
    // gap spans the last two hundredths changes
    task automatic poll_steps(input int k, output int gap);
        logic [7:0] last;
        int t, seen, at;
        @(posedge clk);
        #1;
        {rd_start, rd_addr} = {1'b1, 8'h00};
        @(posedge clk);
        #1;
        last = rd_data;
        {t, seen, at, gap} = {32'd0, 32'd0, 32'd0, 32'd0};
        while (seen < k && t < 8000) begin
            @(posedge clk);
            #1;
            t++;
            if (rd_data !== last) begin
                seen++;
                gap = t - at;
                at = t;
                last = rd_data;
            end
        end
        rd_start = 1'b0;
    endtask
    // long pause in one read, then 32 advances wrap to 00
    task automatic read_wrap(output logic [7:0] h1, h2);
        read_burst(8'h00, 1);
        h1 = rd_buf[0];
        repeat (2700) @(posedge clk);
        #1;
        rd_next = 1'b1;
        repeat (32) @(posedge clk);
        #1;
        rd_next = 1'b0;
        h2 = rd_data;
    endtask
    task automatic pulse_power;
        @(posedge clk);
        #1;
        power_lost = 1'b1;
        @(posedge clk);
        #1;
        power_lost = 1'b0;
    endtask
endmodule

// file: sim/test_rtck_core.sv
// Purpose: self-checking bench for the timekeeping core
// Assumes: x1 period of 8 clocks, fail timeout cut to 64
// Notes: a step is 41 or 40 ticks of 64 cycles
`timescale 1ns/10ps
module test_rtck_core;
    logic clk = 1'b0;
    logic resetn = 1'b1;
    logic x1_in, power_lost, wr_en, rd_start, rd_next, oscillator_alive_flag;
    logic [7:0] wr_addr, wr_data, rd_addr, rd_data;
    logic [7:0] b [0:63];
    int fail_count = 0;
    int tests_run = 0;
    always #20 clk = ~clk;
    rtck_core #(.OSF_CYCLES(64)) rtck_core_inst (.clk(clk), .resetn(resetn), .x1_in(x1_in),
        .power_lost(power_lost), .wr_en(wr_en), .wr_addr(wr_addr), .wr_data(wr_data),
        .rd_start(rd_start), .rd_next(rd_next), .rd_addr(rd_addr), .rd_data(rd_data),
        .oscillator_alive_flag(oscillator_alive_flag));
    rtck_host_model #(.X1_HALF(4)) rtck_host_model_inst (.clk(clk), .x1_in(x1_in),
        .power_lost(power_lost), .wr_en(wr_en), .wr_addr(wr_addr), .wr_data(wr_data),
        .rd_start(rd_start), .rd_next(rd_next), .rd_addr(rd_addr), .rd_data(rd_data),
        .oscillator_alive_flag(oscillator_alive_flag));
    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        tests_run++;
        if (seen !== exp) begin
            fail_count++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic wr(input logic [7:0] a, d);
        rtck_host_model_inst.write_reg(a, d);
    endtask
    task automatic rd(input logic [7:0] a, input int n);
        rtck_host_model_inst.read_burst(a, n);
        b = rtck_host_model_inst.rd_buf;
    endtask
    task automatic test_reset;
        logic [7:0] exp [0:8];
        exp = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h01, 8'h01, 8'h01, 8'h01, 8'h00};
        rd(8'h00, 9);
        for (int i = 0; i < 9; i++) check("reset value", b[i], exp[i]);
        $display("reset done");
    endtask
    task automatic test_osc;
        int n;
        wr(8'h01, 8'h80);
        rtck_host_model_inst.wait_alive(1'b1, n);
        check("start delay", {7'h00, n >= 248 && n <= 256}, 8'h01);
        rd(8'h04, 1);
        check("alive bit", b[0], 8'h21);
        wr(8'h01, 8'h00);
        rtck_host_model_inst.wait_alive(1'b0, n);
        check("fail delay", {7'h00, n >= 54 && n <= 72}, 8'h01);
        wr(8'h08, 8'h08);
        rtck_host_model_inst.wait_alive(1'b1, n);
        check("external start", {7'h00, n >= 248 && n <= 256}, 8'h01);
        wr(8'h01, 8'h80);
        wr(8'h08, 8'h00);
        $display("oscillator done");
    endtask
    task automatic test_misc;
        wr(8'h04, 8'h0F);
        rtck_host_model_inst.pulse_power();
        rd(8'h04, 1);
        check("weekday flags", b[0], 8'h3F);
        wr(8'h04, 8'h07);
        wr(8'h09, 8'hFF);
        wr(8'h08, 8'hFF);
        rd(8'h08, 2);
        check("control", b[0], 8'h7F);
        check("unmapped", b[1], 8'h00);
        rd(8'h04, 1);
        check("weekday cleared", b[0], 8'h27);
        wr(8'h08, 8'h00);
        $display("registers done");
    endtask
    task automatic roll(input logic [7:0] hr, wk, dt, mo, yr, ehr, ewk, edt, emo, eyr);
        int gap;
        logic [7:0] exp [0:7];
        exp = '{8'h00, 8'h80, 8'h00, ehr, ewk, edt, emo, eyr};
        rtck_host_model_inst.load_time(hr, wk, dt, mo, yr);
        rtck_host_model_inst.poll_steps(2, gap);
        rd(8'h00, 8);
        for (int i = 0; i < 8; i++) check("rollover", b[i], exp[i]);
    endtask
    task automatic test_calendar;
        roll(8'h23, 8'h07, 8'h31, 8'h12, 8'h99, 8'h00, 8'h21, 8'h01, 8'h21, 8'h00);
        roll(8'h23, 8'h03, 8'h28, 8'h02, 8'h01, 8'h00, 8'h24, 8'h01, 8'h03, 8'h01);
        roll(8'h23, 8'h03, 8'h28, 8'h02, 8'h04, 8'h00, 8'h24, 8'h29, 8'h22, 8'h04);
        roll(8'h23, 8'h03, 8'h29, 8'h02, 8'h04, 8'h00, 8'h24, 8'h01, 8'h23, 8'h04);
        roll(8'h23, 8'h01, 8'h30, 8'h04, 8'h01, 8'h00, 8'h22, 8'h01, 8'h05, 8'h01);
        roll(8'h23, 8'h01, 8'h31, 8'h01, 8'h01, 8'h00, 8'h22, 8'h01, 8'h02, 8'h01);
        roll(8'h71, 8'h05, 8'h15, 8'h06, 8'h01, 8'h52, 8'h26, 8'h16, 8'h06, 8'h01);
        roll(8'h51, 8'h05, 8'h15, 8'h06, 8'h01, 8'h72, 8'h25, 8'h15, 8'h06, 8'h01);
        roll(8'h09, 8'h05, 8'h15, 8'h06, 8'h01, 8'h10, 8'h25, 8'h15, 8'h06, 8'h01);
        $display("calendar done");
    endtask
    task automatic test_tail;
        int gap;
        logic [7:0] h1, h2;
        rtck_host_model_inst.poll_steps(2, gap);
        check("step gap", {7'h00, gap == 2624 || gap == 2560}, 8'h01);
        rtck_host_model_inst.read_wrap(h1, h2);
        check("wrap refresh", {7'h00, h1 !== h2}, 8'h01);
        $display("step and wrap done");
    endtask
    task automatic close_out;
        $display("comparisons %0d mismatches %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    initial begin
        #1;
        resetn = 1'b0;
        repeat (4) @(posedge clk);
        #1;
        resetn = 1'b1;
        test_reset();
        test_osc();
        test_misc();
        test_calendar();
        test_tail();
        close_out();
    end
    initial begin
        repeat (100000) @(posedge clk);
        fail_count++;
        $display("[FAIL] watchdog expected finish seen timeout");
        close_out();
    end
endmodule
